// [core/pwm_pkg.sv]
// Package for the single-generator PWM unit: register offsets, field layouts,
// action codes and event indices.
// Assumes one system clock and a plain strobe-based register port.
package pwm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int DB_W = 12;

   localparam logic [ADDR_W-1:0] A_CTL = 8'h00;
   localparam logic [ADDR_W-1:0] A_LOAD = 8'h04;
   localparam logic [ADDR_W-1:0] A_COUNT = 8'h08;
   localparam logic [ADDR_W-1:0] A_CMPA = 8'h0C;
   localparam logic [ADDR_W-1:0] A_CMPB = 8'h10;
   localparam logic [ADDR_W-1:0] A_GEN0 = 8'h14;
   localparam logic [ADDR_W-1:0] A_GEN1 = 8'h18;
   localparam logic [ADDR_W-1:0] A_DB_RISE = 8'h1C;
   localparam logic [ADDR_W-1:0] A_DB_FALL = 8'h20;
   localparam logic [ADDR_W-1:0] A_INT_SEL = 8'h24;
   localparam logic [ADDR_W-1:0] A_RAW_STAT = 8'h28;
   localparam logic [ADDR_W-1:0] A_SUMMARY = 8'h2C;
   localparam logic [ADDR_W-1:0] A_OUT_EN = 8'h30;
   localparam logic [ADDR_W-1:0] A_INVERT = 8'h34;
   localparam logic [ADDR_W-1:0] A_FAULT_EN = 8'h38;
   localparam logic [ADDR_W-1:0] A_SYNC = 8'h3C;

   // Control register layout, bit 0 is run
   typedef struct packed {
      logic cmp_sync;
      logic load_sync;
      logic db_en;
      logic updown;
      logic run;
   } ctl_s;
   localparam int CTL_W = $bits(ctl_s);

   // Two-bit action per event for one output
   typedef struct packed {
      logic [1:0] cb_dn;
      logic [1:0] cb_up;
      logic [1:0] ca_dn;
      logic [1:0] ca_up;
      logic [1:0] ld;
      logic [1:0] zr;
   } act_s;
   localparam int ACT_W = $bits(act_s);

   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_INV = 2'h1;
   localparam logic [1:0] ACT_LOW = 2'h2;
   localparam logic [1:0] ACT_HIGH = 2'h3;

   // Event vector indices; interrupt select and raw status share them
   localparam int EV_ZR = 0;
   localparam int EV_LD = 1;
   localparam int EV_CA_UP = 2;
   localparam int EV_CA_DN = 3;
   localparam int EV_CB_UP = 4;
   localparam int EV_CB_DN = 5;
   localparam int EV_N = 6;
   localparam int ST_FAULT = 6;
   localparam int ST_N = 7;

   localparam int SYNC_CNT = 0;
   localparam int SYNC_UPD = 1;

   localparam int N_OUT = 2;

   typedef enum logic {DIR_UP = 1'b0, DIR_DN = 1'b1} dir_e;
endpackage

// [core/pwm_deadband.sv]
// Dead-band stage: makes a complementary pair from input a with separate
// rising-edge delays, or passes both inputs unchanged in bypass.
// Assumes delays are held stable by software while the outputs run.
`timescale 1ns/1ps
module pwm_deadband #(
   parameter int DB_W = pwm_pkg::DB_W
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic [DB_W-1:0] rise_i,
   input wire logic [DB_W-1:0] fall_i,
   input wire logic a_i,
   input wire logic b_i,
   output logic [pwm_pkg::N_OUT-1:0] out_o
);
   import pwm_pkg::*;

   logic [N_OUT-1:0] tgt;
   logic [DB_W-1:0] dly [N_OUT];
   logic [DB_W-1:0] cnt [N_OUT];

   always_comb
   begin
      if (en_i)
      begin
         tgt = {~a_i, a_i};
         dly[0] = rise_i;
         dly[1] = fall_i;
      end
      else
      begin
         tgt = {b_i, a_i};
         dly[0] = '0;
         dly[1] = '0;
      end
   end

   genvar i;
   generate
      for (i = 0; i < N_OUT; i++)
      begin : g_ch
         // Only rising edges wait, so with en_i set both sides are never high together
         always_ff @(posedge mclk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               cnt[i] <= '0;
               out_o[i] <= 1'b0;
            end
            else if (!tgt[i])
            begin
               cnt[i] <= '0;
               out_o[i] <= 1'b0;
            end
            else if (cnt[i] >= dly[i])
               out_o[i] <= 1'b1;
            else
               cnt[i] <= cnt[i] + 1'b1;
         end
      end
   endgenerate
endmodule

// [core/pwm_gen.sv]
// PWM unit: one generator (counter, two comparators, signal builder,
// dead-band stage, interrupt selector) and an output control stage.
// Assumes a register master that strobes one cycle at a time; fault_i is
// synchronous to mclk_i.
//
// Contract
// - 16-bit counter counts down only, or up then down alternately.
// - Programmable 16-bit load value sets the period.
// - Optional: new load value applies only at counter zero or sync.
// - Counter pulses an event at zero and at the load value.
// - Each comparator pulses an event when the count equals its value.
// - Optional: new comparator values apply only at zero or sync.
// - Outputs built by programmed actions on zero, load, compare events.
// - Two independent outputs, or a complementary pair with dead bands.
// - Dead-band bypass passes both signals unchanged.
// - Per-output polarity inversion before the pin.
// - Per-output enable decides whether the signal reaches its pin.
// - Fault input shuts outputs down quickly without software.
// - Per-output choice whether the fault affects it.
// - Interrupt selector picks which events raise the interrupt.
// - Readable summary of the generator interrupt status.
// - Software request syncs the counter and pending updates.
`timescale 1ns/1ps
module pwm_gen #(
   parameter int CNT_W = pwm_pkg::CNT_W,
   parameter int DB_W = pwm_pkg::DB_W
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [pwm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [pwm_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [pwm_pkg::DATA_W-1:0] rdata_o,
   input wire logic fault_i,
   output logic [pwm_pkg::N_OUT-1:0] pwm_o,
   output logic irq_o
);
   import pwm_pkg::*;

   ctl_s ctl;
   logic [CNT_W-1:0] load_shd;
   logic [CNT_W-1:0] load_act;
   logic [CNT_W-1:0] cmpa_shd;
   logic [CNT_W-1:0] cmpa_act;
   logic [CNT_W-1:0] cmpb_shd;
   logic [CNT_W-1:0] cmpb_act;
   act_s gen [N_OUT];
   logic [DB_W-1:0] db_rise;
   logic [DB_W-1:0] db_fall;
   logic [EV_N-1:0] int_sel;
   logic [ST_N-1:0] raw_stat;
   logic [N_OUT-1:0] out_en;
   logic [N_OUT-1:0] invert;
   logic [N_OUT-1:0] fault_en;
   logic [CNT_W-1:0] cnt;
   dir_e dir;
   logic [N_OUT-1:0] sig;
   logic [N_OUT-1:0] db_out;
   logic [EV_N-1:0] ev;
   logic sync_cnt;
   logic sync_upd;
   logic upd_pt;

   function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
      wr_hit = wr_i && (addr_i == a);
   endfunction

   function automatic logic apply_act(input logic cur, input logic [1:0] act);
      unique case (act)
         ACT_NONE: apply_act = cur;
         ACT_INV: apply_act = ~cur;
         ACT_LOW: apply_act = 1'b0;
         ACT_HIGH: apply_act = 1'b1;
      endcase
   endfunction

   // Later events in the list override earlier ones in the same cycle
   function automatic logic build(input logic cur, input act_s a,
                                  input logic [EV_N-1:0] e);
      logic v;
      v = cur;
      if (e[EV_ZR])
         v = apply_act(v, a.zr);
      if (e[EV_LD])
         v = apply_act(v, a.ld);
      if (e[EV_CA_UP])
         v = apply_act(v, a.ca_up);
      if (e[EV_CA_DN])
         v = apply_act(v, a.ca_dn);
      if (e[EV_CB_UP])
         v = apply_act(v, a.cb_up);
      if (e[EV_CB_DN])
         v = apply_act(v, a.cb_dn);
      build = v;
   endfunction

   assign sync_cnt = wr_hit(A_SYNC) && wdata_i[SYNC_CNT];
   assign sync_upd = wr_hit(A_SYNC) && wdata_i[SYNC_UPD];

   // Counter events, qualified by run so a stopped counter stays silent
   always_comb
   begin
      ev = '0;
      if (ctl.run)
      begin
         ev[EV_ZR] = (cnt == '0);
         ev[EV_LD] = (cnt == load_act);
         ev[EV_CA_UP] = (cnt == cmpa_act) && (dir == DIR_UP);
         ev[EV_CA_DN] = (cnt == cmpa_act) && (dir == DIR_DN);
         ev[EV_CB_UP] = (cnt == cmpb_act) && (dir == DIR_UP);
         ev[EV_CB_DN] = (cnt == cmpb_act) && (dir == DIR_DN);
      end
   end

   assign upd_pt = ev[EV_ZR] || sync_upd;

   // Control and configuration registers
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctl <= '0;
         load_shd <= '0;
         cmpa_shd <= '0;
         cmpb_shd <= '0;
         db_rise <= '0;
         db_fall <= '0;
         int_sel <= '0;
         out_en <= '0;
         invert <= '0;
         fault_en <= '0;
      end
      else
      begin
         if (wr_hit(A_CTL))
            ctl <= ctl_s'(wdata_i[CTL_W-1:0]);
         if (wr_hit(A_LOAD))
            load_shd <= wdata_i[CNT_W-1:0];
         if (wr_hit(A_CMPA))
            cmpa_shd <= wdata_i[CNT_W-1:0];
         if (wr_hit(A_CMPB))
            cmpb_shd <= wdata_i[CNT_W-1:0];
         if (wr_hit(A_DB_RISE))
            db_rise <= wdata_i[DB_W-1:0];
         if (wr_hit(A_DB_FALL))
            db_fall <= wdata_i[DB_W-1:0];
         if (wr_hit(A_INT_SEL))
            int_sel <= wdata_i[EV_N-1:0];
         if (wr_hit(A_OUT_EN))
            out_en <= wdata_i[N_OUT-1:0];
         if (wr_hit(A_INVERT))
            invert <= wdata_i[N_OUT-1:0];
         if (wr_hit(A_FAULT_EN))
            fault_en <= wdata_i[N_OUT-1:0];
      end
   end

   // Action tables for the two outputs
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         gen[0] <= '0;
         gen[1] <= '0;
      end
      else
      begin
         if (wr_hit(A_GEN0))
            gen[0] <= act_s'(wdata_i[ACT_W-1:0]);
         if (wr_hit(A_GEN1))
            gen[1] <= act_s'(wdata_i[ACT_W-1:0]);
      end
   end

   // Active load value: immediate, or deferred to the next update point
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         load_act <= '0;
      else if (wr_hit(A_LOAD) && !ctl.load_sync)
         load_act <= wdata_i[CNT_W-1:0];
      else if (upd_pt && ctl.load_sync)
         load_act <= load_shd;
   end

   // With cmp_sync set, a write landing on an update point takes effect one period later
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cmpa_act <= '0;
         cmpb_act <= '0;
      end
      else
      begin
         if (wr_hit(A_CMPA) && !ctl.cmp_sync)
            cmpa_act <= wdata_i[CNT_W-1:0];
         else if (upd_pt && ctl.cmp_sync)
            cmpa_act <= cmpa_shd;
         if (wr_hit(A_CMPB) && !ctl.cmp_sync)
            cmpb_act <= wdata_i[CNT_W-1:0];
         else if (upd_pt && ctl.cmp_sync)
            cmpb_act <= cmpb_shd;
      end
   end

   // Counter and direction
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt <= '0;
         dir <= DIR_DN;
      end
      else if (sync_cnt)
      begin
         cnt <= '0;
         dir <= DIR_UP;
      end
      else if (ctl.run)
      begin
         if (!ctl.updown)
         begin
            dir <= DIR_DN;
            if (cnt == '0)
               cnt <= load_act;
            else
               cnt <= cnt - 1'b1;
         end
         else if (load_act == '0)
            cnt <= '0;
         else if (dir == DIR_UP)
         begin
            if (cnt >= load_act)
            begin
               cnt <= cnt - 1'b1;
               dir <= DIR_DN;
            end
            else
               cnt <= cnt + 1'b1;
         end
         else if (cnt == '0)
         begin
            cnt <= cnt + 1'b1;
            dir <= DIR_UP;
         end
         else
            cnt <= cnt - 1'b1;
      end
   end

   // Signal builder, one flop per output
   genvar i;
   generate
      for (i = 0; i < N_OUT; i++)
      begin : g_sig
         always_ff @(posedge mclk_i or negedge nrst_i)
         begin
            if (!nrst_i)
               sig[i] <= 1'b0;
            else
               sig[i] <= build(sig[i], gen[i], ev);
         end
      end
   endgenerate

   pwm_deadband #(
      .DB_W(DB_W)
   ) u_db (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .en_i(ctl.db_en),
      .rise_i(db_rise),
      .fall_i(db_fall),
      .a_i(sig[0]),
      .b_i(sig[1]),
      .out_o(db_out)
   );

   // Output stage. Fault is taken straight from the pin into the output
   // flop, so shutdown costs one clock; the dead-band path is bypassed here.
   generate
      for (i = 0; i < N_OUT; i++)
      begin : g_out
         always_ff @(posedge mclk_i or negedge nrst_i)
         begin
            if (!nrst_i)
               pwm_o[i] <= 1'b0;
            else if (!out_en[i])
               pwm_o[i] <= 1'b0;
            else if (fault_i && fault_en[i])
               pwm_o[i] <= 1'b0;
            else
               pwm_o[i] <= db_out[i] ^ invert[i];
         end
      end
   endgenerate

   // Sticky event status; a new event wins over a write-one clear
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         raw_stat <= '0;
      else if (wr_hit(A_RAW_STAT))
         raw_stat <= (raw_stat & ~wdata_i[ST_N-1:0]) | {fault_i, ev};
      else
         raw_stat <= raw_stat | {fault_i, ev};
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(raw_stat[EV_N-1:0] & int_sel);
   end

   // Read data stand for exactly one cycle; unmapped reads give zero
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_o <= '0;
      else if (!rd_i)
         rdata_o <= '0;
      else
      begin
         rdata_o <= '0;
         unique case (addr_i)
            A_CTL: rdata_o[CTL_W-1:0] <= ctl;
            A_LOAD: rdata_o[CNT_W-1:0] <= load_shd;
            A_COUNT: rdata_o[CNT_W-1:0] <= cnt;
            A_CMPA: rdata_o[CNT_W-1:0] <= cmpa_shd;
            A_CMPB: rdata_o[CNT_W-1:0] <= cmpb_shd;
            A_GEN0: rdata_o[ACT_W-1:0] <= gen[0];
            A_GEN1: rdata_o[ACT_W-1:0] <= gen[1];
            A_DB_RISE: rdata_o[DB_W-1:0] <= db_rise;
            A_DB_FALL: rdata_o[DB_W-1:0] <= db_fall;
            A_INT_SEL: rdata_o[EV_N-1:0] <= int_sel;
            A_RAW_STAT: rdata_o[ST_N-1:0] <= raw_stat;
            A_SUMMARY: rdata_o[0] <= irq_o;
            A_OUT_EN: rdata_o[N_OUT-1:0] <= out_en;
            A_INVERT: rdata_o[N_OUT-1:0] <= invert;
            A_FAULT_EN: rdata_o[N_OUT-1:0] <= fault_en;
            default: rdata_o <= '0;
         endcase
      end
   end
endmodule

// [tb/pwm_gen_assertions.sv]
// Checker for the PWM unit: bus answers, pin gating, fault cut-off, interrupt mask.
// Assumes it is bound to pwm_gen and sees only its ports.
`timescale 1ns/1ps
module pwm_gen_assertions
   import pwm_pkg::*;
#(
   parameter int CNT_W = pwm_pkg::CNT_W,
   parameter int DB_W = pwm_pkg::DB_W
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [pwm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [pwm_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [pwm_pkg::DATA_W-1:0] rdata_o,
   input wire logic fault_i,
   input wire logic [pwm_pkg::N_OUT-1:0] pwm_o,
   input wire logic irq_o
);
   logic [1:0] oen;
   logic [1:0] inv;
   logic [1:0] fen;
   logic [5:0] sel;
   logic db;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   // Shadows of the settings the pins depend on, tracked from the write strobe
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         oen <= 2'h0;
         inv <= 2'h0;
         fen <= 2'h0;
         sel <= 6'h0;
         db <= 1'b0;
      end
      else if (wr_i)
      begin
         case (addr_i)
            A_OUT_EN: oen <= wdata_i[1:0];
            A_INVERT: inv <= wdata_i[1:0];
            A_FAULT_EN: fen <= wdata_i[1:0];
            A_INT_SEL: sel <= wdata_i[5:0];
            A_CTL: db <= wdata_i[2];
            default: ;
         endcase
      end
   end
   a_oen_read: assert property ($past(rd_i) && $past(addr_i) == A_OUT_EN
      |-> rdata_o == 32'($past(oen))) else $error("output enable read back wrong");
   a_inv_read: assert property ($past(rd_i) && $past(addr_i) == A_INVERT
      |-> rdata_o == 32'($past(inv))) else $error("inversion read back wrong");
   a_fen_read: assert property ($past(rd_i) && $past(addr_i) == A_FAULT_EN
      |-> rdata_o == 32'($past(fen))) else $error("fault enable read back wrong");
   a_sel_read: assert property ($past(rd_i) && $past(addr_i) == A_INT_SEL
      |-> rdata_o == 32'($past(sel))) else $error("interrupt select read back wrong");
   a_pin_gate: assert property ((pwm_o & ~$past(oen)) == 2'h0)
      else $error("disabled pin driven");
   a_fault_cut: assert property (fault_i |=> (pwm_o & $past(fen)) == 2'h0)
      else $error("pin not cut by fault");
   a_irq_mask: assert property (sel == 6'h0 |=> !irq_o)
      else $error("interrupt with empty select");
   a_summary_read: assert property ($past(rd_i) && $past(addr_i) == A_SUMMARY
      |-> rdata_o == 32'($past(irq_o))) else $error("summary differs from interrupt");
   a_db_pair: assert property (db && $past(db, 4) && inv == 2'h0
      && $past(inv, 4) == 2'h0 |-> pwm_o != 2'h3) else $error("pair overlaps");
endmodule

bind pwm_gen pwm_gen_assertions #(.CNT_W(CNT_W), .DB_W(DB_W)) i_pwm_gen_assertions (
   .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .fault_i(fault_i), .pwm_o(pwm_o), .irq_o(irq_o));

// [tb/half_bridge_model.sv]
// Half-H bridge power stage: pin A drives the high switch, pin B the low one.
// Assumes gate levels are registered on the same clock as the PWM unit.
`timescale 1ns/1ps
module half_bridge_model (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [1:0] gate_i,
   output logic shoot_o
);
   // Flags both switches on, which would short the supply
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         shoot_o <= 1'b0;
      else
         shoot_o <= (gate_i == 2'h3);
   end
endmodule

// [tb/tb_pwm_gen.sv]
// Bench for the PWM unit: register tasks, one task per scenario, closing report.
// Assumes pwm_gen with its checker bound and a half-bridge model on the pins.
`timescale 1ns/1ps
module tb_pwm_gen;
   import pwm_pkg::*;
`define CHK(nm, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("mismatch %s expected %0h seen %0h", nm, e, g); \
      end \
   end
   localparam logic [7:0] ZERO_REGS [7] = '{A_CTL, A_COUNT, A_OUT_EN, A_INVERT,
      A_FAULT_EN, A_SYNC, 8'h40};
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = 8'h00;
   logic [DATA_W-1:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic fault_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic [N_OUT-1:0] pwm_o;
   logic irq_o;
   logic shoot;
   logic [2:0] mon;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   assign mon = {shoot, pwm_o};
   pwm_gen i_pwm_gen (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fault_i(fault_i), .pwm_o(pwm_o),
      .irq_o(irq_o));
   half_bridge_model i_half_bridge_model (.mclk_i(mclk_i), .nrst_i(nrst_i), .gate_i(pwm_o),
      .shoot_o(shoot));
   initial
   begin
      forever #20 mclk_i = ~mclk_i;
   end
   task automatic stop_test;
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         stop_test;
      end
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      `CHK("read data", e, rdata_o)
   endtask
   // Counts cycles a monitored level is high; a window of whole periods hides the phase
   task automatic hi(input int b, input int n, input int e);
      int k;
      k = 0;
      repeat (n)
      begin
         @(posedge mclk_i);
         #1;
         if (mon[b] === 1'b1)
            k++;
      end
      `CHK("high cycles", e, k)
   endtask
   task automatic t_reset;
      `CHK("pins", 2'h0, pwm_o)
      `CHK("irq", 1'b0, irq_o)
      foreach (ZERO_REGS[i]) rdc(ZERO_REGS[i], 32'h0);
   endtask
   task automatic t_down;
      wr(A_LOAD, 32'h9);
      wr(A_CMPA, 32'h4);
      wr(A_GEN0, 32'h83);
      wr(A_GEN1, 32'h0E);
      wr(A_OUT_EN, 32'h3);
      wr(A_CTL, 32'h1);
      repeat (12) @(posedge mclk_i);
      hi(0, 20, 12);
      hi(1, 20, 18);
      rdc(A_LOAD, 32'h9);
   endtask
   task automatic t_polarity;
      wr(A_INVERT, 32'h1);
      rdc(A_INVERT, 32'h1);
      hi(0, 20, 8);
      wr(A_INVERT, 32'h0);
      wr(A_OUT_EN, 32'h2);
      rdc(A_OUT_EN, 32'h2);
      hi(0, 20, 0);
      hi(1, 20, 18);
      wr(A_OUT_EN, 32'h3);
   endtask
   task automatic t_fault;
      wr(A_FAULT_EN, 32'h1);
      do @(posedge mclk_i); while (pwm_o[0] !== 1'b1);
      fault_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      `CHK("pin under fault", 1'b0, pwm_o[0])
      hi(0, 20, 0);
      hi(1, 20, 18);
      @(posedge mclk_i);
      fault_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      hi(0, 20, 12);
      wr(A_FAULT_EN, 32'h0);
   endtask
   // A compare write lands just after a pulse: immediate mode shortens the next pulse, synced mode keeps its old width
   task automatic t_cmp_sync;
      for (int s = 0; s < 2; s++)
      begin
         wr(A_CTL, (s == 1) ? 32'h11 : 32'h01);
         wr(A_CMPA, 32'h4);
         repeat (12) @(posedge mclk_i);
         do @(posedge mclk_i); while (pwm_o[0] !== 1'b1);
         do @(posedge mclk_i); while (pwm_o[0] !== 1'b0);
         fork
            wr(A_CMPA, 32'h6);
            hi(0, 20, (s == 1) ? 10 : 8);
         join
      end
   endtask
   // Synced compare mode is left first, else the compare write would wait in the shadow
   task automatic t_deadband;
      wr(A_CTL, 32'h05);
      wr(A_CMPA, 32'h4);
      wr(A_DB_RISE, 32'h2);
      wr(A_DB_FALL, 32'h3);
      repeat (12) @(posedge mclk_i);
      hi(0, 20, 8);
      hi(1, 20, 2);
      hi(2, 20, 0);
   endtask
   task automatic t_updown;
      wr(A_GEN0, 32'h23);
      wr(A_GEN1, 32'h04);
      wr(A_CMPB, 32'h6);
      wr(A_CTL, 32'h3);
      repeat (40) @(posedge mclk_i);
      hi(0, 36, 8);
      hi(1, 36, 18);
      for (int e = 0; e < EV_N; e++)
      begin
         wr(A_RAW_STAT, 32'h7F);
         wr(A_INT_SEL, 32'(1 << e));
         repeat (20) @(posedge mclk_i);
         `CHK("irq", 1'b1, irq_o)
         rdc(A_SUMMARY, 32'h1);
      end
      wr(A_INT_SEL, 32'h0);
      repeat (2) @(posedge mclk_i);
      `CHK("irq", 1'b0, irq_o)
   endtask
   task automatic t_sync;
      wr(A_CTL, 32'h0);
      wr(A_SYNC, 32'h1);
      rdc(A_COUNT, 32'h0);
      repeat (5) @(posedge mclk_i);
      rdc(A_COUNT, 32'h0);
      // Deferred load: the reload at the first zero still uses the old period
      wr(A_CTL, 32'h08);
      wr(A_LOAD, 32'h5);
      wr(A_CTL, 32'h09);
      rdc(A_COUNT, 32'h9);
      wr(A_CTL, 32'h08);
      wr(A_LOAD, 32'h7);
      wr(A_SYNC, 32'h3);
      wr(A_CTL, 32'h09);
      rdc(A_COUNT, 32'h7);
   endtask
   initial
   begin
      repeat (5) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_down;
      t_polarity;
      t_fault;
      t_cmp_sync;
      t_deadband;
      t_updown;
      t_sync;
      stop_test;
   end
endmodule
